//--- src/gpio_defines.svh
// Register offsets, field positions, identification codes and reset values of the pin block.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define OFS_PIN_DIRECTION 12'h000
`define OFS_PIN_LEVEL 12'h004
`define OFS_PIN_CHANGE_IRQ_MASK 12'h008
`define OFS_PIN_CONTROL 12'h00C
`define OFS_MODEM_CONTROL 12'h010
`define OFS_MODEM_STATUS 12'h014
`define OFS_INTERRUPT_IDENT 12'h018
`define OFS_IRQ_STATUS 12'h01C
`define OFS_IRQ_MASK 12'h020

// ==========================================================================
// Pin control fields
`define CTL_LATCH_BIT 0
`define CTL_MODEM_A_BIT 1
`define CTL_MODEM_B_BIT 2
`define CTL_SOFT_RESET_BIT 3

// ==========================================================================
// Modem control fields
`define MCTL_TR_A_BIT 0
`define MCTL_MSI_A_BIT 1
`define MCTL_TR_B_BIT 2
`define MCTL_MSI_B_BIT 3

// ==========================================================================
// Modem line position inside a nibble
`define LINE_SET_READY 0
`define LINE_TERM_READY 1
`define LINE_CARRIER 2
`define LINE_RING 3

// ==========================================================================
// Interrupt status fields
`define IST_PIN_BIT 0
`define IST_MODEM_A_BIT 1
`define IST_MODEM_B_BIT 2

// ==========================================================================
// Identification codes and reset values
`define IDENT_PIN_CHANGE 8'h30
`define IDENT_MODEM 8'h00
`define IDENT_NONE 8'h01
`define RST_BYTE 8'h00
`define RST_CTL 3'h0
`define RST_MCTL 4'h0
`define RST_IRQ 3'h0
`define DTR_MASK 8'h22

`endif

//--- src/gpio_pkg.sv
// Types shared by the pin block.
package gpio_pkg;

	typedef logic [7:0] pin_vec_t;

	typedef enum {
		SRC_NONE,
		SRC_MODEM,
		SRC_PIN
	} irq_src_e;

endpackage

//--- src/pin_sync.sv
// Multi-stage synchroniser for a vector of pins.
`timescale 1ns/10ps
module pin_sync
#(
	parameter int WIDTH = 8,
	parameter int STAGES = 2
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ======================================================================
	// Checks
	if (STAGES < 2)
	begin : g_bad_stages
		$error("pin_sync needs at least two stages");
	end

	logic [WIDTH-1:0] stage_reg [STAGES];
	logic [WIDTH-1:0] stage_next [STAGES];

	// ======================================================================
	// Chain
	always_comb
	begin
		stage_next[0] = async_in;
		for (int i = 1; i < STAGES; i++)
		begin
			stage_next[i] = stage_reg[i-1];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < STAGES; i++)
			begin
				stage_reg[i] <= '0;
			end
		end
		else
		begin
			stage_reg <= stage_next;
		end
	end

	assign sync_out = stage_reg[STAGES-1];

endmodule // pin_sync

//--- src/gpio_modem_mux.sv
// Eight-pin general-purpose port with modem-line nibbles, on an APB slave.
//
// Contract
// - Direction bit n makes pin n an output when 1, input when 0.
// - Written level bits drive every pin configured as an output.
// - Reading the level register returns the real state of all pins except latched pending ones.
// - Mask bit enables change interrupts for its input pin.
// - Modem nibbles ignore the mask; the channel's status enable governs them.
// - Control bit 3 resets the whole block; it reads back as one only in a read whose setup directly follows the write.
// - Control bit 2 turns pins 3 to 0 into channel B modem lines.
// - Control bit 1 turns pins 7 to 4 into channel A modem lines.
// - Unlatched: change interrupts; level read or return to start clears it.
// - Latched: change interrupts and captures the pin value in level.
// - Latched: a level read or leaving latched mode clears; captured value stays meanwhile.
// - Control bits 7 to 4 are reserved and do nothing.
// - Pending pin change shows as priority 5 code in the ident register.
// - In pin mode modem control and status ignore the nibble.
// - In modem mode direction, level and mask ignore the modem lines.
`timescale 1ns/10ps
`include "gpio_defines.svh"
module gpio_modem_mux
	import gpio_pkg::*;
#(
	parameter int NUM_PINS = 8,
	parameter int ADDR_WIDTH = 12
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	// Interrupt
	output logic irq
);

	// ======================================================================
	// Checks
	if (NUM_PINS != 8)
	begin : g_bad_pins
		$error("gpio_modem_mux serves exactly eight pins");
	end
	if (ADDR_WIDTH < 6)
	begin : g_bad_addr
		$error("gpio_modem_mux needs at least six address bits");
	end

	// ======================================================================
	// State
	pin_vec_t dir_reg, dir_next;
	pin_vec_t level_out_reg, level_out_next;
	pin_vec_t mask_reg, mask_next;
	logic [2:0] ctl_reg, ctl_next;
	logic srst_reg, srst_next;
	logic [3:0] mctl_reg, mctl_next;
	pin_vec_t base_reg, base_next;
	pin_vec_t prev_reg, prev_next;
	pin_vec_t lpend_reg, lpend_next;
	pin_vec_t lval_reg, lval_next;
	logic [5:0] ms_prev_reg, ms_prev_next;
	logic [2:1] ist_reg, ist_next;
	logic [2:0] imask_reg, imask_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	pin_vec_t out_reg, out_next;
	pin_vec_t oe_reg, oe_next;
	logic irq_reg, irq_next;

	pin_vec_t pin_s;
	pin_vec_t gp_mask;
	pin_vec_t enabled;
	pin_vec_t pin_pend;
	pin_vec_t level_rd;
	logic [5:0] ms_now;
	logic [2:0] ist_view;
	logic setup, access, wr, rd;
	logic [ADDR_WIDTH-1:0] adr;
	logic mapped;
	logic [7:0] rd_byte;
	irq_src_e src;

	// ======================================================================
	// Input synchroniser
	pin_sync #(
		.WIDTH(8),
		.STAGES(2)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_in),
		.sync_out(pin_s)
	);

	// ======================================================================
	// Next-state logic
	always_comb
	begin
		setup = psel & ~penable;
		access = psel & penable & pready_reg;
		wr = access & pwrite;
		rd = access & ~pwrite;
		adr = paddr;

		// Nibble roles: pins 7..4 follow channel A, pins 3..0 channel B.
		gp_mask = {{4{~ctl_reg[`CTL_MODEM_A_BIT]}},
			{4{~ctl_reg[`CTL_MODEM_B_BIT]}}};
		enabled = mask_reg & ~dir_reg & gp_mask;

		// Active-high modem status: {set_ready, carrier, ring} per channel.
		ms_now[2:0] = {~pin_s[4+`LINE_SET_READY], ~pin_s[4+`LINE_CARRIER],
			~pin_s[4+`LINE_RING]} & {3{ctl_reg[`CTL_MODEM_A_BIT]}};
		ms_now[5:3] = {~pin_s[`LINE_SET_READY], ~pin_s[`LINE_CARRIER],
			~pin_s[`LINE_RING]} & {3{ctl_reg[`CTL_MODEM_B_BIT]}};

		// A latched bit shows the value caught at the change until read.
		level_rd = (lpend_reg & lval_reg) | (~lpend_reg & pin_s);
		if (ctl_reg[`CTL_LATCH_BIT])
		begin
			pin_pend = lpend_reg;
		end
		else
		begin
			pin_pend = enabled & (pin_s ^ base_reg);
		end
		ist_view = {ist_reg, |pin_pend};

		if (|ist_reg)
		begin
			src = SRC_MODEM;
		end
		else if (|pin_pend)
		begin
			src = SRC_PIN;
		end
		else
		begin
			src = SRC_NONE;
		end

		// Address decode.
		mapped = 1'b1;
		rd_byte = 8'h00;
		if (adr == `OFS_PIN_DIRECTION)
		begin
			rd_byte = dir_reg;
		end
		else if (adr == `OFS_PIN_LEVEL)
		begin
			rd_byte = level_rd;
		end
		else if (adr == `OFS_PIN_CHANGE_IRQ_MASK)
		begin
			rd_byte = mask_reg;
		end
		else if (adr == `OFS_PIN_CONTROL)
		begin
			// Soft reset is self-clearing and upper bits stay zero.
			rd_byte = {4'h0, srst_reg, ctl_reg};
		end
		else if (adr == `OFS_MODEM_CONTROL)
		begin
			rd_byte = {4'h0, mctl_reg};
		end
		else if (adr == `OFS_MODEM_STATUS)
		begin
			rd_byte = {1'b0, ms_now[5:3], 1'b0, ms_now[2:0]};
		end
		else if (adr == `OFS_INTERRUPT_IDENT)
		begin
			case (src)
				SRC_MODEM: rd_byte = `IDENT_MODEM;
				SRC_PIN: rd_byte = `IDENT_PIN_CHANGE;
				default: rd_byte = `IDENT_NONE;
			endcase
		end
		else if (adr == `OFS_IRQ_STATUS)
		begin
			rd_byte = {5'h00, ist_view};
		end
		else if (adr == `OFS_IRQ_MASK)
		begin
			rd_byte = {5'h00, imask_reg};
		end
		else
		begin
			mapped = 1'b0;
		end

		// Zero-wait slave: data is prepared in setup, shown in access.
		pready_next = setup;
		pslverr_next = setup & ~mapped;
		prdata_next = (setup & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

		dir_next = dir_reg;
		level_out_next = level_out_reg;
		mask_next = mask_reg;
		ctl_next = ctl_reg;
		mctl_next = mctl_reg;
		imask_next = imask_reg;
		srst_next = 1'b0;
		if (wr & mapped)
		begin
			if (adr == `OFS_PIN_DIRECTION)
			begin
				dir_next = pwdata[7:0];
			end
			else if (adr == `OFS_PIN_LEVEL)
			begin
				level_out_next = pwdata[7:0];
			end
			else if (adr == `OFS_PIN_CHANGE_IRQ_MASK)
			begin
				mask_next = pwdata[7:0];
			end
			else if (adr == `OFS_PIN_CONTROL)
			begin
				ctl_next = pwdata[2:0];
				srst_next = pwdata[`CTL_SOFT_RESET_BIT];
			end
			else if (adr == `OFS_MODEM_CONTROL)
			begin
				mctl_next = pwdata[3:0];
			end
			else if (adr == `OFS_IRQ_MASK)
			begin
				imask_next = pwdata[2:0];
			end
		end

		// Unlatched reference: reset to the value just read, else held; disabled pins track.
		if (rd && adr == `OFS_PIN_LEVEL)
		begin
			base_next = (prdata_reg[7:0] & enabled) | (pin_s & ~enabled);
		end
		else
		begin
			base_next = (base_reg & enabled) | (pin_s & ~enabled);
		end

		// Latched capture; a change in the read cycle survives the clear.
		prev_next = pin_s;
		lval_next = lval_reg;
		lpend_next = lpend_reg;
		if (ctl_reg[`CTL_LATCH_BIT])
		begin
			if (rd && adr == `OFS_PIN_LEVEL)
			begin
				lpend_next = 8'h00;
			end
			for (int i = 0; i < 8; i++)
			begin
				if (enabled[i] && (pin_s[i] != prev_reg[i])
					&& !lpend_next[i])
				begin
					lpend_next[i] = 1'b1;
					lval_next[i] = pin_s[i];
				end
			end
		end
		else
		begin
			lpend_next = 8'h00;
		end

		// Modem change events, gated by each channel's enable.
		ms_prev_next = ms_now;
		ist_next = ist_reg;
		if (wr && adr == `OFS_IRQ_STATUS)
		begin
			ist_next = ist_reg & ~pwdata[2:1];
		end
		if ((|(ms_now[2:0] ^ ms_prev_reg[2:0])) && mctl_reg[`MCTL_MSI_A_BIT])
		begin
			ist_next[`IST_MODEM_A_BIT] = 1'b1;
		end
		if ((|(ms_now[5:3] ^ ms_prev_reg[5:3])) && mctl_reg[`MCTL_MSI_B_BIT])
		begin
			ist_next[`IST_MODEM_B_BIT] = 1'b1;
		end

		// Pin drive: modem nibbles drive terminal-ready only.
		for (int i = 0; i < 8; i++)
		begin
			if (gp_mask[i])
			begin
				oe_next[i] = dir_reg[i];
				out_next[i] = level_out_reg[i] & dir_reg[i];
			end
			else
			begin
				oe_next[i] = 1'(`DTR_MASK >> i);
				out_next[i] = 1'b1;
			end
		end
		// Terminal-ready is active low: a set control bit pulls the pin low.
		if (!gp_mask[4+`LINE_TERM_READY])
		begin
			out_next[4+`LINE_TERM_READY] = ~mctl_reg[`MCTL_TR_A_BIT];
		end
		if (!gp_mask[`LINE_TERM_READY])
		begin
			out_next[`LINE_TERM_READY] = ~mctl_reg[`MCTL_TR_B_BIT];
		end

		irq_next = |(ist_view & imask_reg);

		// Soft reset clears every control and event register at once.
		if (srst_reg)
		begin
			dir_next = `RST_BYTE;
			level_out_next = `RST_BYTE;
			mask_next = `RST_BYTE;
			ctl_next = `RST_CTL;
			mctl_next = `RST_MCTL;
			imask_next = `RST_IRQ;
			ist_next = 2'b00;
			lpend_next = `RST_BYTE;
			lval_next = `RST_BYTE;
			base_next = pin_s;
		end
	end

	// ======================================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dir_reg <= `RST_BYTE;
			level_out_reg <= `RST_BYTE;
			mask_reg <= `RST_BYTE;
			ctl_reg <= `RST_CTL;
			srst_reg <= 1'b0;
			mctl_reg <= `RST_MCTL;
			base_reg <= `RST_BYTE;
			prev_reg <= `RST_BYTE;
			lpend_reg <= `RST_BYTE;
			lval_reg <= `RST_BYTE;
			ms_prev_reg <= 6'h00;
			ist_reg <= 2'b00;
			imask_reg <= `RST_IRQ;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			out_reg <= `RST_BYTE;
			oe_reg <= `RST_BYTE;
			irq_reg <= 1'b0;
		end
		else
		begin
			dir_reg <= dir_next;
			level_out_reg <= level_out_next;
			mask_reg <= mask_next;
			ctl_reg <= ctl_next;
			srst_reg <= srst_next;
			mctl_reg <= mctl_next;
			base_reg <= base_next;
			prev_reg <= prev_next;
			lpend_reg <= lpend_next;
			lval_reg <= lval_next;
			ms_prev_reg <= ms_prev_next;
			ist_reg <= ist_next;
			imask_reg <= imask_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
			irq_reg <= irq_next;
		end
	end

	// ======================================================================
	// Outputs
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign pin_out = out_reg;
	assign pin_oe = oe_reg;
	assign irq = irq_reg;

endmodule // gpio_modem_mux

//--- sim/gpio_modem_mux_asserts.sv
// Concurrent checks on the ports of the pin block.
`timescale 1ns/10ps
`include "gpio_defines.svh"
module gpio_modem_mux_asserts
	import gpio_pkg::*;
#(
	parameter int ADDR_WIDTH = 12
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and interrupt
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic irq
);
	// ========
	// Shadow of the programmed state
	logic acc;
	logic wr;
	logic rd;
	logic bad;
	logic srst_q;
	logic [2:0] ctl_q;
	logic [2:0] im_q;
	pin_vec_t dir_q;
	pin_vec_t lvl_q;
	pin_vec_t gp;
	pin_vec_t m;
	pin_vec_t exp_oe;
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign bad = paddr > `OFS_IRQ_MASK || paddr[1:0] != 2'h0;
	assign gp = {{4{!ctl_q[1]}}, {4{!ctl_q[2]}}};
	assign m = dir_q & gp;
	assign exp_oe = m | (~gp & `DTR_MASK);
	// The shadow clears a cycle late, as the block does after a soft reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			srst_q <= 1'b0;
			{ctl_q, im_q, dir_q, lvl_q} <= '0;
		end
		else
		begin
			srst_q <= wr && paddr == `OFS_PIN_CONTROL && pwdata[3];
			if (srst_q)
				{ctl_q, im_q, dir_q, lvl_q} <= '0;
			else if (wr && paddr == `OFS_PIN_DIRECTION)
				dir_q <= pwdata[7:0];
			else if (wr && paddr == `OFS_PIN_LEVEL)
				lvl_q <= pwdata[7:0];
			else if (wr && paddr == `OFS_PIN_CONTROL)
				ctl_q <= pwdata[2:0];
			else if (wr && paddr == `OFS_IRQ_MASK)
				im_q <= pwdata[2:0];
		end
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_ctl_reset;
		wr && paddr == `OFS_PIN_CONTROL && pwdata[3];
	endsequence
	// ========
	// Assertions
	chk_ready_access: assert property (s_setup |=> acc)
		else $error("pready missing after setup");
	chk_unmapped_err: assert property (acc |->
		pslverr == bad && (!bad || prdata == 32'h0))
		else $error("pslverr wrong for address");
	chk_oe_role: assert property (
		$stable(exp_oe) |-> pin_oe == exp_oe)
		else $error("pin_oe differs from programmed role");
	chk_out_level: assert property (
		$stable(m) && $stable(lvl_q) |-> (pin_out & m) == (lvl_q & m))
		else $error("pin_out differs from level");
	chk_read_pins: assert property (
		$stable(pin_in)[*4] ##0 (rd && paddr == `OFS_PIN_LEVEL && !ctl_q[0])
		|-> prdata[7:0] == pin_in)
		else $error("level read differs from pins");
	chk_ctl_readback: assert property (
		rd && paddr == `OFS_PIN_CONTROL |-> prdata[31:3] == 29'h0)
		else $error("control reads set reserved bits");
	chk_soft_reset: assert property (
		s_ctl_reset |-> ##[1:4] (pin_oe == 8'h00 && !irq))
		else $error("soft reset left pins driven");
	chk_ident_code: assert property (
		rd && paddr == `OFS_INTERRUPT_IDENT |-> prdata[7:0] inside
		{`IDENT_MODEM, `IDENT_PIN_CHANGE, `IDENT_NONE})
		else $error("unknown ident code");
	chk_mask_quiet: assert property (im_q == 3'h0 && $past(im_q) == 3'h0
		|-> !irq)
		else $error("irq with all sources masked");
endmodule // gpio_modem_mux_asserts

bind gpio_modem_mux gpio_modem_mux_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) chk_inst (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .irq
);

//--- sim/pin_world.sv
// External pin model: resolves each pin from the block and the far side.
`timescale 1ns/10ps
module pin_world
(
	// Block side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Far side
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_drv,
	// Resolved levels
	output logic [7:0] pin_in
);
	// Undriven pins are pulled up, so a floating line never reads as X.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
		| (~pin_oe & ~ext_drv);
endmodule // pin_world

//--- sim/tb_gpio_modem_mux.sv
// Self-checking bench for the pin block.
`timescale 1ns/10ps
`include "gpio_defines.svh"
module tb_gpio_modem_mux
	import gpio_pkg::*;
;
	typedef struct {logic [11:0] a; pin_vec_t w; pin_vec_t e;} row_s;
	logic pclk;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic err;
	pin_vec_t pin_in, pin_out, pin_oe, rdat;
	pin_vec_t ext_val = 8'h50;
	pin_vec_t ext_drv = 8'hF0;
	int n_errors = 0;
	int tests_run = 0;
	row_s rows [4] = '{
		'{`OFS_PIN_CHANGE_IRQ_MASK, 8'h10, 8'h10},
		'{`OFS_PIN_CONTROL, 8'hF0, 8'h00},
		'{`OFS_IRQ_MASK, 8'h07, 8'h07},
		'{`OFS_PIN_DIRECTION, 8'h0F, 8'h0F}};
	gpio_modem_mux gpio_modem_mux_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in,
		.pin_out, .pin_oe, .irq);
	pin_world pin_world_inst (.pin_out, .pin_oe, .ext_val, .ext_drv, .pin_in);
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ========
	// Bus and compare tasks
	task automatic apb(input logic w, input logic [11:0] a, input pin_vec_t d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready.
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rdat = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string s, input pin_vec_t e, input pin_vec_t g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_errors++;
		test_done;
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("oe", 8'h00, pin_oe);
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 8'h00);
			chk("row", rows[i].e, rdat);
		end
		apb(1'b1, `OFS_PIN_LEVEL, 8'h03);
		repeat (4) @(posedge pclk);
		chk("oe", 8'h0F, pin_oe);
		chk("out", 8'h03, pin_out & pin_oe);
		apb(1'b0, `OFS_PIN_LEVEL, 8'h00);
		chk("level", 8'h53, rdat);
		ext_val <= 8'h40;
		repeat (6) @(posedge pclk);
		chk("irq", 8'h01, 8'(irq));
		ext_val <= 8'h50;
		repeat (6) @(posedge pclk);
		chk("irq", 8'h00, 8'(irq));
		ext_val <= 8'h40;
		repeat (4) @(posedge pclk);
		apb(1'b0, `OFS_INTERRUPT_IDENT, 8'h00);
		chk("ident", `IDENT_PIN_CHANGE, rdat);
		apb(1'b0, `OFS_PIN_LEVEL, 8'h00);
		ext_val <= 8'h60;
		repeat (6) @(posedge pclk);
		chk("irq", 8'h00, 8'(irq));
		apb(1'b1, `OFS_PIN_CONTROL, 8'h01);
		ext_val <= 8'h70;
		repeat (4) @(posedge pclk);
		ext_val <= 8'h60;
		repeat (6) @(posedge pclk);
		chk("irq", 8'h01, 8'(irq));
		apb(1'b0, `OFS_PIN_LEVEL, 8'h00);
		chk("level", 8'h73, rdat);
		repeat (3) @(posedge pclk);
		chk("irq", 8'h00, 8'(irq));
		apb(1'b1, `OFS_PIN_CONTROL, 8'h02);
		repeat (6) @(posedge pclk);
		chk("irq", 8'h00, 8'(irq));
		chk("oe", 8'h2F, pin_oe);
		apb(1'b1, `OFS_MODEM_CONTROL, 8'h03);
		ext_val <= 8'hE0;
		repeat (6) @(posedge pclk);
		chk("irq", 8'h01, 8'(irq));
		chk("out", 8'h00, pin_out & 8'h20);
		apb(1'b0, `OFS_MODEM_STATUS, 8'h00);
		chk("status", 8'h04, rdat);
		apb(1'b1, `OFS_IRQ_STATUS, 8'h02);
		apb(1'b1, `OFS_PIN_CONTROL, 8'h06);
		repeat (4) @(posedge pclk);
		chk("irq", 8'h00, 8'(irq));
		chk("oe", 8'h22, pin_oe);
		apb(1'b1, `OFS_PIN_CONTROL, 8'h08);
		repeat (4) @(posedge pclk);
		chk("oe", 8'h00, pin_oe);
		apb(1'b0, `OFS_PIN_CONTROL, 8'h00);
		chk("control", 8'h00, rdat);
		apb(1'b0, 12'h024, 8'h00);
		chk("slverr", 8'h01, 8'(err));
		chk("unmapped", 8'h00, rdat);
		test_done;
	end
endmodule // tb_gpio_modem_mux
